// file: design/pmc_consts.svh
// offsets, field positions, reset values and timing counts of the power mode controller
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH
`define PMC_OFF_MODE_CTRL 8'h00
`define PMC_OFF_ACT_TMPL 8'h04
`define PMC_OFF_ALT_TMPL 8'h08
`define PMC_OFF_WAKE_EN 8'h0C
`define PMC_OFF_REG_CTRL 8'h10
`define PMC_OFF_STATUS 8'h14
`define PMC_NSUB 8
`define PMC_SUB_CPU 0
`define PMC_SUB_FLASH 1
`define PMC_SUB_I2C 2
`define PMC_SUB_CMP 3
`define PMC_ACT_TMPL_RST 8'hFF
`define PMC_ALT_TMPL_RST 8'hFC
`define PMC_WAKE_EN_RST 6'h3F
`define PMC_REG_CTRL_RST 2'h3
`define PMC_MODE_ACTIVE 2'h0
`define PMC_MODE_ALT 2'h1
`define PMC_MODE_SLEEP 2'h2
`define PMC_MODE_HIB 2'h3
`define PMC_WK_CMP 0
`define PMC_WK_PORT 1
`define PMC_WK_I2C 2
`define PMC_WK_RTC 3
`define PMC_WK_TW 4
`define PMC_WK_LVD 5
`define PMC_NWAKE 6
`define PMC_CLK_MHZ 100
`define PMC_HIB_RESUME_US 100
`define PMC_HIB_RESUME_CYC ((`PMC_HIB_RESUME_US * `PMC_CLK_MHZ))
`define PMC_BUZZ_PERIOD 16
`define PMC_BUZZ_ON 2
`endif

// file: design/pmc_pkg.sv
// types of the power mode controller
`include "pmc_consts.svh"
package pmc_pkg;
   typedef enum logic [1:0] {
      PMC_ACTIVE,
      PMC_ALT_ACTIVE,
      PMC_SLEEP,
      PMC_HIBERNATE
   } pmc_mode_t;
   typedef enum logic [1:0] {
      PMC_RD_IDLE,
      PMC_RD_RESP
   } pmc_rd_t;
   typedef struct packed {
      pmc_mode_t mode;
      logic cpu_off;
      logic [`PMC_NSUB-1:0] act_tmpl;
      logic [`PMC_NSUB-1:0] alt_tmpl;
      logic [`PMC_NWAKE-1:0] wake_en;
      logic [1:0] reg_ctrl;
      logic [`PMC_NSUB-1:0] sub_en;
      logic [`PMC_NSUB-1:0] clk_gate;
      logic lowspeed_en;
      logic hib_reg_en;
      logic dig_reg_en;
      logic analog_reg_en;
      logic buzz;
      logic [3:0] buzz_cnt;
      logic [15:0] resume_cnt;
      logic resuming;
      logic aw_got;
      logic w_got;
      logic [7:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic awready;
      logic wready;
      logic arready;
      pmc_rd_t rd;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [`PMC_NWAKE-1:0] wake_s1;
      logic [`PMC_NWAKE-1:0] wake_s2;
      logic [`PMC_NWAKE-1:0] io_ok_s1;
      logic [`PMC_NWAKE-1:0] io_ok_s2;
   } pmc_state_t;
endpackage

// file: design/pmc_power_mode_controller.sv
// global power mode controller with AXI4-Lite register slave
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "pmc_consts.svh"
// Behaviour
// RQ1 - four modes: active, alternate, sleep, hibernate
// RQ2 - active mode enables follow active template
// RQ3 - disabled subsystem has its clocks gated
// RQ4 - template writes take effect immediately
// RQ5 - cpu may stop itself, wakeup restarts
// RQ6 - wakeup forces active mode, cpu enabled
// RQ7 - mode after reset is active
// RQ8 - alternate active uses its own template
// RQ9 - sleep disables most subsystems regardless
// RQ10 - sleep keeps low-speed timers running
// RQ11 - hibernate stops clocks, port wakeup only
// RQ12 - hibernate keeps only hibernate regulator
// RQ13 - sleep buzzes digital and analog regulators
// RQ14 - core regulators on after reset
// RQ15 - firmware waits for valid io supplies
// RQ16 - low modes entered only by register write
// RQ17 - sleep wakeup from six listed sources
// RQ18 - hibernate resume within 100 us
module pmc_power_mode_controller
   import pmc_pkg::*;
(
   input wire logic CLK,
   input wire logic SRST,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic [5:0] WAKE_IN,
   input wire logic [5:0] IO_SUPPLY_OK,
   output logic [7:0] SUB_ENABLE,
   output logic [7:0] SUB_CLK_GATE,
   output logic [1:0] POWER_MODE,
   output logic LOWSPEED_CLK_EN,
   output logic DIG_REG_EN,
   output logic ANALOG_REG_EN,
   output logic REG_BUZZ,
   output logic HIB_REG_EN,
   output logic RESUMING
);
   localparam logic [15:0] RESUME_CYC = 16'(`PMC_HIB_RESUME_CYC - 10);
   localparam logic [3:0] BUZZ_LAST = 4'(`PMC_BUZZ_PERIOD - 1);
   localparam logic [3:0] BUZZ_ON = 4'(`PMC_BUZZ_ON);

   pmc_state_t q, d;

   function automatic logic is_reg(input logic [7:0] a);
      is_reg = (a == `PMC_OFF_MODE_CTRL) || (a == `PMC_OFF_ACT_TMPL) ||
               (a == `PMC_OFF_ALT_TMPL) || (a == `PMC_OFF_WAKE_EN) ||
               (a == `PMC_OFF_REG_CTRL) || (a == `PMC_OFF_STATUS);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] st);
      merge = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            merge[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
   endfunction

   always_comb begin
      logic [31:0] m;
      logic [`PMC_NWAKE-1:0] wk;
      logic wake;
      logic io_ok;
      logic [`PMC_NSUB-1:0] t;
      m = 32'h0;
      t = '0;
      wk = '0;
      wake = 1'b0;
      io_ok = 1'b0;
      d = q;
      d.wake_s1 = WAKE_IN;
      d.wake_s2 = q.wake_s1;
      d.io_ok_s1 = IO_SUPPLY_OK;
      d.io_ok_s2 = q.io_ok_s1;
      io_ok = &q.io_ok_s2;
      wk = q.wake_s2 & q.wake_en;
      // hibernate accepts port interrupt only
      if (q.mode == PMC_HIBERNATE) begin
         wake = wk[`PMC_WK_PORT]; // RQ11 RQ18
      end else begin
         wake = |wk; // RQ17
      end
      // register write
      d.awready = 1'b0;
      d.wready = 1'b0;
      if (S_AXI_AWVALID && !q.aw_got && !q.bvalid && !q.awready) begin
         d.awready = 1'b1;
         d.aw_got = 1'b1;
         d.aw_addr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !q.w_got && !q.bvalid && !q.wready) begin
         d.wready = 1'b1;
         d.w_got = 1'b1;
         d.w_data = S_AXI_WDATA;
         d.w_strb = S_AXI_WSTRB;
      end
      if (q.bvalid && S_AXI_BREADY) begin
         d.bvalid = 1'b0;
      end
      if (q.aw_got && q.w_got && !q.bvalid) begin
         d.aw_got = 1'b0;
         d.w_got = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = is_reg(q.aw_addr) ? 2'h0 : 2'h2;
         case (q.aw_addr)
            `PMC_OFF_MODE_CTRL: begin
               m = merge({29'h0, q.cpu_off, q.mode}, q.w_data, q.w_strb);
               // low modes need valid io supplies
               if (m[1:0] == `PMC_MODE_ACTIVE || m[1:0] == `PMC_MODE_ALT || io_ok) begin
                  d.mode = pmc_mode_t'(m[1:0]); // RQ16 RQ15
               end
               d.cpu_off = m[2]; // RQ5
               if (m[1:0] == `PMC_MODE_HIB) begin
                  d.resuming = 1'b0;
               end
            end
            `PMC_OFF_ACT_TMPL: begin
               m = merge({24'h0, q.act_tmpl}, q.w_data, q.w_strb);
               d.act_tmpl = m[7:0]; // RQ4
            end
            `PMC_OFF_ALT_TMPL: begin
               m = merge({24'h0, q.alt_tmpl}, q.w_data, q.w_strb);
               d.alt_tmpl = m[7:0]; // RQ4 RQ8
            end
            `PMC_OFF_WAKE_EN: begin
               m = merge({26'h0, q.wake_en}, q.w_data, q.w_strb);
               d.wake_en = m[5:0];
            end
            `PMC_OFF_REG_CTRL: begin
               m = merge({30'h0, q.reg_ctrl}, q.w_data, q.w_strb);
               d.reg_ctrl = m[1:0]; // RQ14
            end
            default: begin
               m = 32'h0;
            end
         endcase
      end
      // wakeup wins over a simultaneous mode write, except in active mode with the cpu running, where the write takes effect
      if (wake && (q.mode != PMC_ACTIVE || q.cpu_off || !q.act_tmpl[`PMC_SUB_CPU])) begin
         if (q.mode == PMC_HIBERNATE) begin
            d.resuming = 1'b1;
            d.resume_cnt = 16'h0;
         end
         d.mode = PMC_ACTIVE; // RQ6
         d.cpu_off = 1'b0; // RQ5 RQ6
         // a cpu switched off through its template bit comes back on as well
         d.act_tmpl[`PMC_SUB_CPU] = 1'b1; // RQ6
      end
      if (q.resuming) begin
         d.resume_cnt = q.resume_cnt + 16'h1;
         if (q.resume_cnt >= RESUME_CYC) begin
            d.resuming = 1'b0; // RQ18
         end
      end
      // register read
      d.arready = 1'b0;
      case (q.rd)
         PMC_RD_IDLE: begin
            if (S_AXI_ARVALID && !q.arready) begin
               d.arready = 1'b1;
               d.rresp = is_reg(S_AXI_ARADDR) ? 2'h0 : 2'h2;
               case (S_AXI_ARADDR)
                  `PMC_OFF_MODE_CTRL: d.rdata = {29'h0, q.cpu_off, q.mode};
                  `PMC_OFF_ACT_TMPL: d.rdata = {24'h0, q.act_tmpl};
                  `PMC_OFF_ALT_TMPL: d.rdata = {24'h0, q.alt_tmpl};
                  `PMC_OFF_WAKE_EN: d.rdata = {26'h0, q.wake_en};
                  `PMC_OFF_REG_CTRL: d.rdata = {30'h0, q.reg_ctrl};
                  `PMC_OFF_STATUS: d.rdata = {4'h0, q.sub_en, q.io_ok_s2, q.wake_s2, 3'h0,
                                             q.resuming, q.buzz, 1'b0, q.mode}; // RQ1
                  default: d.rdata = 32'h0;
               endcase
            end else if (q.arready) begin
               // read data only follows the address handshake edge
               d.rd = PMC_RD_RESP;
            end
         end
         PMC_RD_RESP: begin
            if (S_AXI_RREADY) begin
               d.rd = PMC_RD_IDLE;
            end
         end
         default: d.rd = PMC_RD_IDLE;
      endcase
      // subsystem enables per mode
      case (q.mode)
         PMC_ACTIVE: t = q.act_tmpl; // RQ2
         PMC_ALT_ACTIVE: t = q.alt_tmpl; // RQ8
         PMC_SLEEP: t = '0; // RQ9
         PMC_HIBERNATE: t = '0; // RQ12
         default: t = '0;
      endcase
      if (q.mode == PMC_SLEEP) begin
         t[`PMC_SUB_I2C] = 1'b1; // RQ9
         t[`PMC_SUB_CMP] = 1'b1;
      end
      if (q.cpu_off) begin
         t[`PMC_SUB_CPU] = 1'b0; // RQ5
      end
      d.sub_en = t; // RQ4
      d.clk_gate = ~t; // RQ3
      d.lowspeed_en = (q.mode != PMC_HIBERNATE); // RQ10 RQ11
      // regulators: buzz in sleep, only hibernate regulator in hibernate
      d.buzz_cnt = (q.mode == PMC_SLEEP) ? q.buzz_cnt + 4'h1 : 4'h0;
      if (q.buzz_cnt == BUZZ_LAST) begin
         d.buzz_cnt = 4'h0;
      end
      d.buzz = (q.mode == PMC_SLEEP); // RQ13
      d.hib_reg_en = (q.mode == PMC_HIBERNATE); // RQ12
      if (q.mode == PMC_HIBERNATE) begin
         d.dig_reg_en = 1'b0; // RQ12
         d.analog_reg_en = 1'b0;
      end else if (q.mode == PMC_SLEEP) begin
         d.dig_reg_en = q.reg_ctrl[0] && (q.buzz_cnt < BUZZ_ON); // RQ13
         d.analog_reg_en = q.reg_ctrl[1] && (q.buzz_cnt < BUZZ_ON);
      end else begin
         d.dig_reg_en = q.reg_ctrl[0]; // RQ14
         d.analog_reg_en = q.reg_ctrl[1];
      end
      if (SRST) begin
         d = '0;
         d.mode = PMC_ACTIVE; // RQ7
         d.rd = PMC_RD_IDLE;
         d.act_tmpl = `PMC_ACT_TMPL_RST;
         d.alt_tmpl = `PMC_ALT_TMPL_RST;
         d.wake_en = `PMC_WAKE_EN_RST;
         d.reg_ctrl = `PMC_REG_CTRL_RST; // RQ14
         d.sub_en = `PMC_ACT_TMPL_RST;
         d.clk_gate = ~`PMC_ACT_TMPL_RST;
         d.lowspeed_en = 1'b1;
         d.dig_reg_en = 1'b1;
         d.analog_reg_en = 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      q <= d;
   end

   assign S_AXI_AWREADY = q.awready;
   assign S_AXI_WREADY = q.wready;
   assign S_AXI_BVALID = q.bvalid;
   assign S_AXI_BRESP = q.bresp;
   assign S_AXI_ARREADY = q.arready;
   assign S_AXI_RVALID = (q.rd == PMC_RD_RESP);
   assign S_AXI_RDATA = q.rdata;
   assign S_AXI_RRESP = q.rresp;
   assign SUB_ENABLE = q.sub_en;
   assign SUB_CLK_GATE = q.clk_gate;
   assign POWER_MODE = q.mode;
   assign LOWSPEED_CLK_EN = q.lowspeed_en;
   assign DIG_REG_EN = q.dig_reg_en;
   assign ANALOG_REG_EN = q.analog_reg_en;
   assign REG_BUZZ = q.buzz;
   assign HIB_REG_EN = q.hib_reg_en;
   assign RESUMING = q.resuming;
endmodule

// file: sim/pmc_properties.sv
// port assertions of the power mode controller
`timescale 1ns/1ps
module pmc_chk (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic [5:0] WAKE_IN,
   input wire logic [7:0] SUB_ENABLE,
   input wire logic [7:0] SUB_CLK_GATE,
   input wire logic [1:0] POWER_MODE,
   input wire logic LOWSPEED_CLK_EN,
   input wire logic DIG_REG_EN,
   input wire logic ANALOG_REG_EN,
   input wire logic REG_BUZZ,
   input wire logic HIB_REG_EN,
   input wire logic RESUMING
);
   logic [15:0] res_q;
   default clocking @(posedge CLK); endclocking
   default disable iff (SRST);
   // length of the current resume indication
   always_ff @(posedge CLK) begin
      res_q <= (SRST || !RESUMING) ? 16'h0 : res_q + 16'h1;
   end
   chk_gate_inv: assert property (
      SUB_CLK_GATE == ~SUB_ENABLE) else $error("gate not inverse of enable");
   chk_boot_state: assert property (
      $fell(SRST) |-> POWER_MODE == 2'h0 && SUB_ENABLE == 8'hFF && DIG_REG_EN && ANALOG_REG_EN)
      else $error("bad state after reset");
   chk_sleep_off: assert property (
      (POWER_MODE == 2'h2) [*2] |-> REG_BUZZ && LOWSPEED_CLK_EN && (SUB_ENABLE & 8'hF3) == 8'h0)
      else $error("sleep outputs wrong");
   chk_buzz_short: assert property (
      (POWER_MODE == 2'h2) [*4] |-> !(DIG_REG_EN && $past(DIG_REG_EN) && $past(DIG_REG_EN, 2)))
      else $error("regulator not pulsed in sleep");
   chk_hib_only: assert property (
      (POWER_MODE == 2'h3) [*2] |-> HIB_REG_EN && !DIG_REG_EN && !ANALOG_REG_EN
         && !LOWSPEED_CLK_EN && SUB_ENABLE == 8'h0) else $error("hibernate outputs wrong");
   chk_hib_port: assert property (
      (POWER_MODE == 2'h3 && !WAKE_IN[1]) [*6] |=> POWER_MODE == 2'h3)
      else $error("hibernate left without port wake");
   chk_alt_wake: assert property (
      (POWER_MODE == 2'h1 && WAKE_IN[0]) [*2] |-> ##[1:5] (POWER_MODE == 2'h0 && SUB_ENABLE[0]))
      else $error("wake did not restore active");
   chk_resume_len: assert property (
      res_q <= 16'd10001) else $error("resume too long");
endmodule
bind pmc_power_mode_controller pmc_chk u_chk (.CLK(CLK), .SRST(SRST), .WAKE_IN(WAKE_IN),
   .SUB_ENABLE(SUB_ENABLE), .SUB_CLK_GATE(SUB_CLK_GATE), .POWER_MODE(POWER_MODE),
   .LOWSPEED_CLK_EN(LOWSPEED_CLK_EN), .DIG_REG_EN(DIG_REG_EN), .ANALOG_REG_EN(ANALOG_REG_EN),
   .REG_BUZZ(REG_BUZZ), .HIB_REG_EN(HIB_REG_EN), .RESUMING(RESUMING));

// file: sim/tb_top.sv
// self-checking bench of the power mode controller
`timescale 1ns/1ps
`include "pmc_consts.svh"
module tb_top;
   logic clk, srst, awv, wv, bv, bready, arv, arr, rv, rready, awr, wrr;
   logic lsp, dig, ana, buzz, hib, resm;
   logic [7:0] awaddr, araddr, sub_en, gate;
   logic [31:0] wdata, rdata, rd;
   logic [5:0] wake, io_ok;
   logic [1:0] bresp, rresp, resp, pmode;
   int err_total, n_checks;
   pmc_power_mode_controller DUT (.CLK(clk), .SRST(srst), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
      .S_AXI_WVALID(wv), .S_AXI_WREADY(wrr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
      .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready),
      .WAKE_IN(wake), .IO_SUPPLY_OK(io_ok), .SUB_ENABLE(sub_en), .SUB_CLK_GATE(gate),
      .POWER_MODE(pmode), .LOWSPEED_CLK_EN(lsp), .DIG_REG_EN(dig), .ANALOG_REG_EN(ana),
      .REG_BUZZ(buzz), .HIB_REG_EN(hib), .RESUMING(resm));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         err_total++;
         $display("Error t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      fork
         begin
            do @(posedge clk); while (!awr);
            awv <= 1'b0;
         end
         begin
            do @(posedge clk); while (!wrr);
            wv <= 1'b0;
         end
      join
      while (!bv) @(posedge clk);
      resp = bresp;
      bready <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (!arr);
      arv <= 1'b0;
      while (!rv) @(posedge clk);
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask
   task automatic pulse(input int i);
      @(posedge clk);
      wake[i] <= 1'b1;
      tick(4);
      wake[i] <= 1'b0;
      tick(4);
   endtask
   task automatic go(input logic [31:0] m);
      wr(`PMC_OFF_MODE_CTRL, m);
      tick(3);
   endtask
   task automatic t_boot();
      chk({pmode, sub_en, dig, ana, lsp}, 13'h7FF);
      rdr(`PMC_OFF_REG_CTRL);
      chk(rd, `PMC_REG_CTRL_RST);
      rdr(8'h18);
      chk(rd, 32'h0);
      chk(resp, 2'h2);
      wr(8'h1C, 32'h1);
      chk(resp, 2'h2);
      wr(`PMC_OFF_REG_CTRL, 32'h0);
      tick(2);
      chk({dig, ana}, 2'h0);
      wr(`PMC_OFF_REG_CTRL, 32'h3);
      $display("boot done");
   endtask
   task automatic t_alt();
      wr(`PMC_OFF_ACT_TMPL, 32'hA4);
      tick(2);
      chk({sub_en, gate}, 16'hA45B);
      go(`PMC_MODE_ALT);
      chk({pmode, sub_en}, {2'h1, 8'hFC});
      rdr(`PMC_OFF_STATUS);
      chk(rd, 32'h0FCFC001);
      pulse(`PMC_WK_CMP);
      chk({pmode, sub_en}, {2'h0, 8'hA5});
      go(32'h4);
      chk(sub_en[0], 1'b0);
      pulse(`PMC_WK_RTC);
      chk(sub_en[0], 1'b1);
      wr(`PMC_OFF_ACT_TMPL, 32'hFF);
      $display("alt done");
   endtask
   task automatic t_sleep();
      int n;
      io_ok <= 6'h3E;
      tick(3);
      go(`PMC_MODE_SLEEP);
      chk(pmode, `PMC_MODE_ACTIVE);
      io_ok <= 6'h3F;
      tick(3);
      for (int i = 0; i < `PMC_NWAKE; i++) begin
         go(`PMC_MODE_SLEEP);
         chk({pmode, buzz, lsp, sub_en}, 12'hB0C);
         n = 0;
         repeat (`PMC_BUZZ_PERIOD) begin
            @(posedge clk);
            n += dig;
         end
         chk(n, `PMC_BUZZ_ON);
         pulse(i);
         chk(pmode, `PMC_MODE_ACTIVE);
      end
      $display("sleep done");
   endtask
   task automatic t_hib();
      int n;
      go(`PMC_MODE_HIB);
      chk({pmode, hib, dig, ana, lsp, sub_en}, 14'h3800);
      pulse(`PMC_WK_CMP);
      chk(pmode, `PMC_MODE_HIB);
      pulse(`PMC_WK_PORT);
      chk({pmode, resm}, 3'h1);
      n = 0;
      while (resm) begin
         @(posedge clk);
         n++;
      end
      chk(n <= `PMC_HIB_RESUME_CYC, 1'b1);
      rdr(`PMC_OFF_ALT_TMPL);
      chk(rd, `PMC_ALT_TMPL_RST);
      $display("hib done");
   endtask
   initial begin
      srst = 1'b1;
      {awv, wv, bready, arv, rready} = 5'h0;
      {awaddr, araddr, wdata, wake} = '0;
      io_ok = 6'h3F;
      tick(8);
      srst <= 1'b0;
      t_boot();
      t_alt();
      t_sleep();
      t_hib();
      final_report();
   end
   initial begin
      tick(40000);
      err_total++;
      final_report();
   end
endmodule
